// ### flash_ctrl_pkg.sv
// constants, types and decode helpers shared by the flash register block
// Function
// - page selector picks one of 128 pages
// - page erase sets whole 512-byte page to ffh
// - shared address reaches protection when enabled
// - info select bit maps fe00h to ffffh
// - page field drives flash address bits 15:9
// - 5eh command routes shared address to protection
// - protection bits readable, writable to one only
// - set sector bit blocks user program and erase
// - high and low bytes form 16-bit khz value
// - option bit low refuses user program and erase
// - option bit high permits program and page erase
// - unlock needs page, 73h, 8ch, page again
// - writing 00h resets controller to locked
// - unlocked programming only inside selected page
// - status field reports the unlock progress codes
package flash_ctrl_pkg;
   // ****************************************
   // register addresses
   // ****************************************
   localparam logic [11:0] CTL_ADDR = 12'hff8; // control write, status read
   localparam logic [11:0] PAGE_ADDR = 12'hff9; // page select or protection
   localparam logic [11:0] KHZ_HI_ADDR = 12'hffa; // clock khz high byte
   localparam logic [11:0] KHZ_LO_ADDR = 12'hffb; // clock khz low byte
   localparam logic [11:0] OPT_ADDR = 12'hffc; // option and busy view
   // ****************************************
   // control commands
   // ****************************************
   localparam logic [7:0] CMD_LOCK = 8'h00;
   localparam logic [7:0] CMD_UNLOCK1 = 8'h73;
   localparam logic [7:0] CMD_UNLOCK2 = 8'h8c;
   localparam logic [7:0] CMD_PROT = 8'h5e;
   localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
   localparam logic [7:0] CMD_MASS_ERASE = 8'h63;
   // ****************************************
   // status codes
   // ****************************************
   localparam logic [5:0] ST_LOCKED = 6'h00;
   localparam logic [5:0] ST_FIRST = 6'h01;
   localparam logic [5:0] ST_SECOND = 6'h02;
   localparam logic [5:0] ST_UNLOCKED = 6'h03;
   localparam logic [5:0] ST_PROT = 6'h04;
   localparam logic [5:0] ST_PROG = 6'h08;
   localparam logic [5:0] ST_PERASE = 6'h10;
   localparam logic [5:0] ST_MERASE = 6'h20;
   // ****************************************
   // fields and reset values
   // ****************************************
   localparam logic [7:0] PAGE_RESET = 8'h00;
   localparam logic [7:0] PROT_RESET = 8'h00;
   localparam logic [7:0] KHZ_RESET = 8'h00;
   localparam int INFO_BIT = 7; // info select bit of page register
   localparam int PAGE_LSB = 9; // lowest address bit of page number
   localparam logic [6:0] INFO_PAGE = 7'h7f; // fe00h..ffffh window
   localparam logic [8:0] PAGE_BASE = 9'h000; // offset of erase start
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam logic [3:0] PROG_SHIFT = 4'h6; // program time = khz/64 cycles
   // ****************************************
   // control state, one-hot
   // ****************************************
   typedef enum logic [4:0] {
      LOCKED = 5'b00001,
      FIRST = 5'b00010,
      SECOND = 5'b00100,
      UNLOCKED = 5'b01000,
      PROT_SEL = 5'b10000
   } ctl_state_type;
   // sector of a page: top three page bits
   function automatic logic [2:0] sector_of(input logic [6:0] page);
      sector_of = page[6:4];
   endfunction : sector_of
endpackage : flash_ctrl_pkg

// ### flash_unlock_seq.sv
// control register unlock sequencer
`timescale 1ns/1ps
module flash_unlock_seq (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic ctl_wr_i,
   input wire logic [7:0] ctl_data_i,
   input wire logic page_wr_i,
   input wire logic erase_done_i,
   output flash_ctrl_pkg::ctl_state_type state_o
);
   // page written since locked state was last entered
   logic page_seen;
   flash_ctrl_pkg::ctl_state_type next_state;
   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      next_state = state_o;
      if (ctl_wr_i && ctl_data_i == flash_ctrl_pkg::CMD_LOCK) begin
         next_state = flash_ctrl_pkg::LOCKED;
      end else begin
         case (state_o)
            flash_ctrl_pkg::LOCKED: begin
               if (ctl_wr_i && ctl_data_i == flash_ctrl_pkg::CMD_UNLOCK1 && page_seen) begin
                  next_state = flash_ctrl_pkg::FIRST;
               end else if (ctl_wr_i && ctl_data_i == flash_ctrl_pkg::CMD_PROT) begin
                  next_state = flash_ctrl_pkg::PROT_SEL;
               end
            end
            flash_ctrl_pkg::FIRST: begin
               // wrong command drops back to locked
               if (ctl_wr_i) begin
                  next_state = (ctl_data_i == flash_ctrl_pkg::CMD_UNLOCK2) ?
                     flash_ctrl_pkg::SECOND : flash_ctrl_pkg::LOCKED;
               end
            end
            flash_ctrl_pkg::SECOND: begin
               if (ctl_wr_i) begin
                  next_state = flash_ctrl_pkg::LOCKED;
               end else if (page_wr_i) begin
                  next_state = flash_ctrl_pkg::UNLOCKED;
               end
            end
            flash_ctrl_pkg::UNLOCKED: begin
               // erase ends in locked state
               if (erase_done_i) begin
                  next_state = flash_ctrl_pkg::LOCKED;
               end
            end
            flash_ctrl_pkg::PROT_SEL: begin
               next_state = flash_ctrl_pkg::PROT_SEL;
            end
            default: begin
               next_state = flash_ctrl_pkg::LOCKED;
            end
         endcase
      end
   end
   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state_o <= flash_ctrl_pkg::LOCKED;
      end else if (ce_i) begin
         state_o <= next_state;
      end
   end
   // page seen flag, reloaded from the page write when locked is entered from another state
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         page_seen <= 1'b0;
      end else if (ce_i) begin
         if (next_state == flash_ctrl_pkg::LOCKED && state_o != flash_ctrl_pkg::LOCKED) begin
            page_seen <= page_wr_i;
         end else if (page_wr_i) begin
            page_seen <= 1'b1;
         end
      end
   end
endmodule : flash_unlock_seq

// ### flash_op_timer.sv
// program and erase duration counter
`timescale 1ns/1ps
module flash_op_timer (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic start_i,
   input wire logic [15:0] cycles_i,
   output logic busy_o,
   output logic done_o
);
   // cycles still to run
   logic [15:0] remain;
   // ****************************************
   // countdown; zero length runs one cycle
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         remain <= 16'h0000;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else if (ce_i) begin
         done_o <= 1'b0;
         if (start_i && !busy_o) begin
            remain <= (cycles_i == 16'h0000) ? 16'h0001 : cycles_i;
            busy_o <= 1'b1;
         end else if (busy_o) begin
            if (remain == 16'h0001) begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
            end
            remain <= remain - 16'h0001;
         end
      end
   end
endmodule : flash_op_timer

// ### flash_page_protect_timing_regs.sv
// flash page select, sector protection and clock timing registers
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module flash_page_protect_timing_regs (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic prog_req_i,
   input wire logic [15:0] prog_addr_i,
   input wire logic [7:0] prog_data_i,
   input wire logic user_write_permit_option_i,
   input wire logic dbg_mass_erase_i,
   output logic [15:0] flash_addr_o,
   output logic [7:0] flash_wdata_o,
   output logic flash_prog_o,
   output logic flash_page_erase_o,
   output logic flash_mass_erase_o,
   output logic flash_info_sel_o,
   output logic flash_busy_o,
   output logic [15:0] flash_clock_khz_o,
   output logic [7:0] sector_lock_o
);

   // ****************************************
   // declarations
   // ****************************************
   logic [7:0] flash_page_select; // info bit and page number
   logic [7:0] flash_sector_protection; // one sector_lock_bit per sector
   logic [7:0] flash_clock_khz_high; // khz value, upper byte
   logic [7:0] flash_clock_khz_low; // khz value, lower byte
   logic [15:0] flash_clock_khz; // combined khz value
   logic [1:0] permit_sync; // option bit synchroniser
   logic [1:0] dbg_sync; // debugger request synchroniser
   logic permit_s; // synchronised option bit
   logic dbg_s; // synchronised debugger request
   logic dbg_prev; // for debugger request edge
   flash_ctrl_pkg::ctl_state_type state; // unlock sequencer state
   logic [5:0] op_code; // running operation status
   logic [5:0] controller_state_field; // reported status
   logic ctl_wr; // control register write
   logic page_wr; // page select write
   logic prot_wr; // protection write
   logic sel_locked; // selected page in locked sector
   logic prog_ok; // user program accepted
   logic perase_ok; // user page erase accepted
   logic merase_ok; // mass erase accepted
   logic op_start; // launch timed operation
   logic [15:0] op_cycles; // length of launched operation
   logic busy; // timer running
   logic done; // timer finished
   logic erase_done; // timed erase finished
   logic [6:0] page_num; // page field alone

   // ****************************************
   // decode
   // ****************************************
   assign page_num = flash_page_select[6:0];
   assign flash_clock_khz = {flash_clock_khz_high, flash_clock_khz_low};
   assign ctl_wr = reg_wr_i && reg_addr_i == flash_ctrl_pkg::CTL_ADDR && !busy;

   // shared address: protection while selected, else page select
   assign prot_wr = reg_wr_i && reg_addr_i == flash_ctrl_pkg::PAGE_ADDR
      && state == flash_ctrl_pkg::PROT_SEL;
   assign page_wr = reg_wr_i && reg_addr_i == flash_ctrl_pkg::PAGE_ADDR
      && state != flash_ctrl_pkg::PROT_SEL && !busy;
   assign sel_locked = flash_sector_protection[flash_ctrl_pkg::sector_of(page_num)];
   assign permit_s = permit_sync[1];
   assign dbg_s = dbg_sync[1];

   // user program: unlocked, permitted, unprotected, inside page
   assign prog_ok = prog_req_i && !busy && state == flash_ctrl_pkg::UNLOCKED && permit_s
      && !sel_locked
      && prog_addr_i[15:flash_ctrl_pkg::PAGE_LSB] == page_num;
   assign perase_ok = ctl_wr && reg_wdata_i == flash_ctrl_pkg::CMD_PAGE_ERASE
      && state == flash_ctrl_pkg::UNLOCKED && permit_s && !sel_locked;

   // mass erase: debugger when idle and no user program or page erase starts, user only with permit
   assign merase_ok = !busy && ((dbg_s && !dbg_prev) || (ctl_wr
      && reg_wdata_i == flash_ctrl_pkg::CMD_MASS_ERASE
      && state == flash_ctrl_pkg::UNLOCKED && permit_s
      && flash_sector_protection == flash_ctrl_pkg::PROT_RESET));
   assign op_start = prog_ok || perase_ok || merase_ok;

   // erase lasts one millisecond, program khz/64 cycles
   assign op_cycles = prog_ok ? (flash_clock_khz >> flash_ctrl_pkg::PROG_SHIFT) : flash_clock_khz;
   assign erase_done = done && op_code != flash_ctrl_pkg::ST_PROG;

   // ****************************************
   // input synchronisers
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         permit_sync <= 2'h0;
         dbg_sync <= 2'h0;
         dbg_prev <= 1'b0;
      end else if (ce_i) begin
         permit_sync <= {permit_sync[0], user_write_permit_option_i};
         dbg_sync <= {dbg_sync[0], dbg_mass_erase_i};
         dbg_prev <= dbg_s;
      end
   end

   // ****************************************
   // submodules
   // ****************************************
   flash_unlock_seq u_seq (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .ctl_wr_i(ctl_wr),
      .ctl_data_i(reg_wdata_i),
      .page_wr_i(page_wr),
      .erase_done_i(erase_done),
      .state_o(state)
   );
   flash_op_timer u_timer (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .start_i(op_start),
      .cycles_i(op_cycles),
      .busy_o(busy),
      .done_o(done)
   );

   // ****************************************
   // registers
   // ****************************************
   // page select, one of 128 pages plus info bit
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         flash_page_select <= flash_ctrl_pkg::PAGE_RESET;
      end else if (ce_i && page_wr) begin
         flash_page_select <= reg_wdata_i;
      end
   end

   // protection: ones set, zeros ignored, never cleared
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         flash_sector_protection <= flash_ctrl_pkg::PROT_RESET;
      end else if (ce_i && prot_wr) begin
         flash_sector_protection <= flash_sector_protection | reg_wdata_i;
      end
   end

   // clock frequency bytes
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         flash_clock_khz_high <= flash_ctrl_pkg::KHZ_RESET;
         flash_clock_khz_low <= flash_ctrl_pkg::KHZ_RESET;
      end else if (ce_i && reg_wr_i && !busy) begin
         if (reg_addr_i == flash_ctrl_pkg::KHZ_HI_ADDR) begin
            flash_clock_khz_high <= reg_wdata_i;
         end
         if (reg_addr_i == flash_ctrl_pkg::KHZ_LO_ADDR) begin
            flash_clock_khz_low <= reg_wdata_i;
         end
      end
   end

   // running operation code
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         op_code <= flash_ctrl_pkg::ST_LOCKED;
      end else if (ce_i) begin
         if (op_start) begin
            op_code <= prog_ok ? flash_ctrl_pkg::ST_PROG :
               perase_ok ? flash_ctrl_pkg::ST_PERASE : flash_ctrl_pkg::ST_MERASE;
         end else if (done) begin
            op_code <= flash_ctrl_pkg::ST_LOCKED;
         end
      end
   end

   // ****************************************
   // status field
   // ****************************************
   always_comb begin
      if (busy) begin
         controller_state_field = op_code;
      end else begin
         case (state)
            flash_ctrl_pkg::LOCKED: controller_state_field = flash_ctrl_pkg::ST_LOCKED;
            flash_ctrl_pkg::FIRST: controller_state_field = flash_ctrl_pkg::ST_FIRST;
            flash_ctrl_pkg::SECOND: controller_state_field = flash_ctrl_pkg::ST_SECOND;
            flash_ctrl_pkg::UNLOCKED: controller_state_field = flash_ctrl_pkg::ST_UNLOCKED;
            flash_ctrl_pkg::PROT_SEL: controller_state_field = flash_ctrl_pkg::ST_PROT;
            default: controller_state_field = flash_ctrl_pkg::ST_LOCKED;
         endcase
      end
   end

   // ****************************************
   // read port, data in the following cycle only
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 8'h00;
      end else if (ce_i) begin
         reg_rdata_o <= 8'h00;
         if (reg_rd_i) begin
            case (reg_addr_i)
               flash_ctrl_pkg::CTL_ADDR: reg_rdata_o <= {2'h0, controller_state_field};
               flash_ctrl_pkg::PAGE_ADDR: begin
                  // shared address read follows the routing
                  reg_rdata_o <= (state == flash_ctrl_pkg::PROT_SEL) ?
                     flash_sector_protection : flash_page_select;
               end
               flash_ctrl_pkg::KHZ_HI_ADDR: reg_rdata_o <= flash_clock_khz_high;
               flash_ctrl_pkg::KHZ_LO_ADDR: reg_rdata_o <= flash_clock_khz_low;
               flash_ctrl_pkg::OPT_ADDR: reg_rdata_o <= {6'h00, busy, permit_s};
               default: reg_rdata_o <= 8'h00; // unmapped reads zero
            endcase
         end
      end
   end

   // ****************************************
   // flash array strobes
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         flash_prog_o <= 1'b0;
         flash_page_erase_o <= 1'b0;
         flash_mass_erase_o <= 1'b0;
         flash_addr_o <= 16'h0000;
         flash_wdata_o <= 8'h00;
         flash_info_sel_o <= 1'b0;
      end else if (ce_i) begin
         flash_prog_o <= prog_ok;
         flash_page_erase_o <= perase_ok;
         flash_mass_erase_o <= merase_ok && !prog_ok && !perase_ok;
         if (prog_ok) begin
            flash_addr_o <= prog_addr_i;
            flash_wdata_o <= prog_data_i;
            flash_info_sel_o <= flash_page_select[flash_ctrl_pkg::INFO_BIT]
               && prog_addr_i[15:flash_ctrl_pkg::PAGE_LSB] == flash_ctrl_pkg::INFO_PAGE;
         end else if (perase_ok) begin
            // whole page: page number over zero offset, erased value
            flash_addr_o <= {page_num, flash_ctrl_pkg::PAGE_BASE};
            flash_wdata_o <= flash_ctrl_pkg::ERASED_BYTE;
            flash_info_sel_o <= flash_page_select[flash_ctrl_pkg::INFO_BIT]
               && page_num == flash_ctrl_pkg::INFO_PAGE;
         end else if (merase_ok) begin
            flash_addr_o <= 16'h0000;
            flash_wdata_o <= flash_ctrl_pkg::ERASED_BYTE;
            flash_info_sel_o <= 1'b0;
         end
      end
   end

   // exported views
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         flash_busy_o <= 1'b0;
         flash_clock_khz_o <= 16'h0000;
         sector_lock_o <= flash_ctrl_pkg::PROT_RESET;
      end else if (ce_i) begin
         flash_busy_o <= busy;
         flash_clock_khz_o <= flash_clock_khz;
         sector_lock_o <= flash_sector_protection;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_second_cmd;
      ce_i && ctl_wr && reg_wdata_i == flash_ctrl_pkg::CMD_UNLOCK2 && state == flash_ctrl_pkg::FIRST;
   endsequence
   sequence s_rewrite_page;
      ce_i && page_wr && !ctl_wr && state == flash_ctrl_pkg::SECOND;
   endsequence

   a_unlock_second: assert property (s_second_cmd |=> state == flash_ctrl_pkg::SECOND)
      else $error("second unlock command not taken");
   a_unlock_final: assert property (s_rewrite_page |=> state == flash_ctrl_pkg::UNLOCKED)
      else $error("page rewrite did not unlock");
   a_lock_cmd: assert property (ce_i && ctl_wr && reg_wdata_i == flash_ctrl_pkg::CMD_LOCK
      |=> state == flash_ctrl_pkg::LOCKED)
      else $error("lock command ignored");
   a_prog_in_page: assert property (flash_prog_o |-> $past(state) == flash_ctrl_pkg::UNLOCKED
      && flash_addr_o[15:9] == $past(page_num) && $past(permit_s))
      else $error("program outside unlocked page");
   a_prog_unlocked: assert property (flash_prog_o || flash_page_erase_o
      |-> !sector_lock_o[flash_ctrl_pkg::sector_of(flash_addr_o[15:9])])
      else $error("program or erase in locked sector");
   a_wp_erase: assert property (flash_page_erase_o |-> $past(permit_s))
      else $error("erase while user writes disabled");
   a_erase_fill: assert property (flash_page_erase_o |-> flash_wdata_o == flash_ctrl_pkg::ERASED_BYTE
      && flash_addr_o[8:0] == flash_ctrl_pkg::PAGE_BASE)
      else $error("page erase value or base wrong");
   a_prot_sticky: assert property (rst_n_i && $past(rst_n_i)
      |-> (flash_sector_protection & $past(flash_sector_protection)) == $past(flash_sector_protection))
      else $error("protection bit cleared");
   a_prot_route: assert property (ce_i && prot_wr |=> flash_page_select == $past(flash_page_select)
      && flash_sector_protection == ($past(flash_sector_protection) | $past(reg_wdata_i)))
      else $error("shared address routed wrongly");
   a_status_code: assert property (ce_i && reg_rd_i && reg_addr_i == flash_ctrl_pkg::CTL_ADDR && !busy
      && state == flash_ctrl_pkg::SECOND |=> reg_rdata_o == 8'h02)
      else $error("status code wrong");
   a_khz_low: assert property (ce_i && reg_wr_i && !busy && reg_addr_i == flash_ctrl_pkg::KHZ_LO_ADDR
      |=> ##1 flash_clock_khz_o[7:0] == $past(reg_wdata_i, 2) || !$past(ce_i))
      else $error("khz low byte not combined");

   // protection select command
   sequence s_prot_cmd;
      ce_i && ctl_wr && reg_wdata_i == flash_ctrl_pkg::CMD_PROT && state == flash_ctrl_pkg::LOCKED;
   endsequence
   a_prot_select: assert property (s_prot_cmd |=> state == flash_ctrl_pkg::PROT_SEL)
      else $error("protection select not taken");

   // user mass erase needs permit, no lock
   a_mass_gate: assert property (flash_mass_erase_o |-> ($past(dbg_s) && !$past(dbg_prev))
      || ($past(permit_s) && $past(flash_sector_protection) == flash_ctrl_pkg::PROT_RESET))
      else $error("mass erase without permission");

   // locked sector never reaches the array
   a_locked_refuse: assert property (ce_i && prog_req_i && sel_locked |=> !flash_prog_o)
      else $error("program into locked sector");

   // info flag only on the top page
   a_info_map: assert property (flash_info_sel_o && (flash_prog_o || flash_page_erase_o)
      |-> flash_addr_o[15:flash_ctrl_pkg::PAGE_LSB] == flash_ctrl_pkg::INFO_PAGE)
      else $error("info area outside top page");

   // erase address carries the page number
   a_erase_page: assert property (flash_page_erase_o
      |-> flash_addr_o[15:flash_ctrl_pkg::PAGE_LSB] == $past(page_num))
      else $error("erase page address wrong");

   // page frozen while an operation runs
   a_page_frozen: assert property (ce_i && busy && reg_wr_i && reg_addr_i == flash_ctrl_pkg::PAGE_ADDR
      && state != flash_ctrl_pkg::PROT_SEL |=> flash_page_select == $past(flash_page_select))
      else $error("page changed during operation");

   // high byte lands in the upper half
   a_khz_high: assert property (ce_i && reg_wr_i && !busy && reg_addr_i == flash_ctrl_pkg::KHZ_HI_ADDR
      |=> ##1 flash_clock_khz_o[15:8] == $past(reg_wdata_i, 2) || !$past(ce_i))
      else $error("khz high byte not combined");
endmodule : flash_page_protect_timing_regs

// ### flash_array_model.sv
// behavioural flash array behind the register block
`timescale 1ns/1ps
module flash_array_model (
   input wire logic clk_i,
   input wire logic [15:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic prog_i,
   input wire logic page_erase_i,
   input wire logic mass_erase_i
);
   logic [7:0] mem [0:65535]; // array contents, erased at start
   initial begin
      for (int i = 0; i < 65536; i++) mem[i] = 8'hff;
   end
   // programming only clears bits, erases set bytes to ff
   always @(posedge clk_i) begin
      if (prog_i) mem[addr_i] <= mem[addr_i] & wdata_i;
      if (page_erase_i) for (int i = 0; i < 512; i++) mem[{addr_i[15:9], i[8:0]}] <= 8'hff;
      if (mass_erase_i) for (int i = 0; i < 65536; i++) mem[i] <= 8'hff;
   end
endmodule : flash_array_model

// ### flash_page_protect_timing_regs_tb.sv
// self-checking bench for the flash register block
`timescale 1ns/1ps
module flash_page_protect_timing_regs_tb;
   logic clk, rst_n, wr, rd, preq, permit, dbg, fprog, fpe, fme, finfo, busy;
   logic [11:0] addr;
   logic [7:0] wd, pd, rdata, lock, fwd;
   logic [15:0] pa, faddr, khz;
   int fail_count = 0;
   int checked = 0;
   flash_page_protect_timing_regs dut (.clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .reg_addr_i(addr),
      .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .prog_req_i(preq),
      .prog_addr_i(pa), .prog_data_i(pd), .user_write_permit_option_i(permit), .dbg_mass_erase_i(dbg),
      .flash_addr_o(faddr), .flash_wdata_o(fwd), .flash_prog_o(fprog), .flash_page_erase_o(fpe),
      .flash_mass_erase_o(fme), .flash_info_sel_o(finfo), .flash_busy_o(busy), .flash_clock_khz_o(khz),
      .sector_lock_o(lock));
   flash_array_model fm (.clk_i(clk), .addr_i(faddr), .wdata_i(fwd), .prog_i(fprog),
      .page_erase_i(fpe), .mass_erase_i(fme));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   // read data stands one cycle after the strobe
   task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask : rd_chk
   task automatic idle();
      repeat (3) @(posedge clk);
      for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk);
   endtask : idle
   task automatic prog(input logic [15:0] a, input logic [7:0] d, input logic e);
      @(posedge clk);
      pa <= a;
      pd <= d;
      preq <= 1'b1;
      @(posedge clk);
      preq <= 1'b0;
      #1 chk(fprog, e);
      idle();
   endtask : prog
   task automatic unlock(input logic [7:0] p);
      wr_reg(12'hff8, 8'h00);
      wr_reg(12'hff9, p);
      wr_reg(12'hff8, 8'h73);
      rd_chk(12'hff8, 8'h01);
      wr_reg(12'hff8, 8'h8c);
      rd_chk(12'hff8, 8'h02);
      wr_reg(12'hff9, p);
      rd_chk(12'hff8, 8'h03);
   endtask : unlock
   task automatic final_report();
      if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   // watchdog against a hang
   initial begin
      #200000;
      fail_count++;
      final_report();
   end
   initial begin
      {wr, rd, preq, dbg, rst_n, addr, wd, pa, pd} = '0;
      permit = 1'b1;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(12'hff9, 8'h00);
      // 258 khz stands for a legal slow system clock
      wr_reg(12'hffa, 8'h01);
      wr_reg(12'hffb, 8'h02);
      repeat (2) @(posedge clk);
      #1 chk(khz, 16'h0102);
      unlock(8'h05);
      prog(16'h0a10, 8'h3c, 1'b1);
      chk(fm.mem[16'h0a10], 16'h003c);
      prog(16'h0c10, 8'h00, 1'b0);
      wr_reg(12'hff8, 8'h95);
      #1 chk(fpe, 1'b1);
      chk(faddr, 16'h0a00);
      rd_chk(12'hffc, 8'h03);
      rd_chk(12'hff8, 8'h10);
      chk(busy, 1'b1);
      idle();
      chk(fm.mem[16'h0a10], 16'h00ff);
      rd_chk(12'hff8, 8'h00);
      unlock(8'hff);
      prog(16'hfe00, 8'h12, 1'b1);
      chk(finfo, 1'b1);
      wr_reg(12'hff8, 8'h00);
      wr_reg(12'hff8, 8'h5e);
      rd_chk(12'hff8, 8'h04);
      wr_reg(12'hff9, 8'h01);
      wr_reg(12'hff9, 8'h00);
      rd_chk(12'hff9, 8'h01);
      chk(lock, 8'h01);
      wr_reg(12'hff8, 8'h00);
      rd_chk(12'hff9, 8'hff);
      unlock(8'h05);
      prog(16'h0a20, 8'h00, 1'b0);
      chk(fm.mem[16'h0a20], 16'h00ff);
      unlock(8'h10);
      @(posedge clk);
      permit <= 1'b0;
      repeat (3) @(posedge clk);
      prog(16'h2000, 8'h00, 1'b0);
      permit <= 1'b1;
      repeat (3) @(posedge clk);
      prog(16'h2000, 8'h55, 1'b1);
      chk(fm.mem[16'h2000], 16'h0055);
      wr_reg(12'hff8, 8'h63);
      #1 chk(fme, 1'b0);
      wr_reg(12'hff8, 8'h00);
      rd_chk(12'hff8, 8'h00);
      @(posedge clk);
      permit <= 1'b0;
      dbg <= 1'b1;
      for (int i = 0; i < 8 && fme !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      chk(fme, 1'b1);
      @(posedge clk);
      dbg <= 1'b0;
      idle();
      chk(fm.mem[16'h2000], 16'h00ff);
      chk(fm.mem[16'h0001], 16'h00ff);
      final_report();
   end
endmodule : flash_page_protect_timing_regs_tb
